// >>> hdl/dhb_bridge.sv
// device end: indirect access bridge with local mac register space
`timescale 1ns/1ps
module dhb_bridge
    import dhb_pkg::*;
(
    input  wire logic             clock,            // 20 MHz clock
    input  wire logic             rst_b,            // async reset, low
    dhb_if.bridge                 bus,              // register bus
    input  wire logic             bridgeSelectEnable, // bridge answers
    input  wire logic [CFG_VEC_W-1:0] staticConfigVector, // tie-offs
    input  wire logic             pcsMode,          // pcs layer in use
    input  wire logic [1:0]       syncAcquiredStatus, // per mac
    input  wire logic [63:0]      statsValue,       // counter value
    input  wire logic [31:0]      phyReadValue,     // phy read result
    output logic [1:0]            flowTxEnable,     // per mac
    output logic [1:0]            flowRxEnable,     // per mac
    output logic [1:0]            mgmtEnable,       // per mac
    output logic [1:0]            txAllowed,        // per mac
    output logic [10:0]           statsAddr         // counter address
);
    logic [31:0] dataHigh_reg, dataLow_reg, control_reg, ready_reg;
    logic [31:0] flowCtl_reg [2];
    logic [31:0] mgmtCfg_reg [2];
    logic [47:0] mcTable_reg [2][4];
    logic [31:0] mcWord0_reg [2];
    logic [2:0]  cnt_reg;
    logic        busy_reg, ack_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  tx_reg;

    wire        ctlWr  = bus.req && bus.wr && bridgeSelectEnable && bus.idx == IDX_CONTROL;
    wire        isWr   = control_reg[CTL_WREN_BIT];                         // [R3]
    wire        mac    = control_reg[CTL_SEL_BIT];                          // [R14]
    wire [9:0]  adr    = control_reg[CTL_ADDR_W-1:0];
    wire        isCfg  = adr[9] && adr != ADR_MDIO_ADDR && adr != ADR_MDIO_DATA;
    wire        isStat = !adr[9];
    wire        isMdio = adr == ADR_MDIO_ADDR;
    wire [1:0]  mcIdx  = dataLow_reg[MC_IDX_LSB+1:MC_IDX_LSB];
    // read only without the store flag; index bit 0 doubles as that flag, so only even entries read back
    wire        mcRead = isWr && adr == ADR_MC_WORD1 && dataLow_reg[MC_RNW_BIT] && !dataLow_reg[MC_WR_BIT]; // [R8]
    wire        done   = busy_reg && cnt_reg == 3'(XFER_CYCLES-1);
    wire        anOff  = !staticConfigVector[CFG_AUTONEG];

    // register port: reads answer the cycle after the request
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            dataHigh_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= bus.req && bridgeSelectEnable;
            unique case (bus.idx)                                           // [R6]
                IDX_DATA_HIGH: rdata_reg <= dataHigh_reg;
                IDX_DATA_LOW:  rdata_reg <= dataLow_reg;
                IDX_CONTROL:   rdata_reg <= control_reg;
                IDX_READY:     rdata_reg <= ready_reg;
                default:       rdata_reg <= 32'h0000_0000;
            endcase
            if (bus.req && bus.wr && bus.idx == IDX_DATA_HIGH)
                dataHigh_reg <= bus.wdata;
            else if (done && !isWr && isStat)
                dataHigh_reg <= statsValue[63:32];                          // [R5]
            else if (done && mcRead)
                dataHigh_reg <= {16'h0000, mcTable_reg[mac][mcIdx][47:32]}; // [R8]
        end
    end

    // control, transaction counter and ready flags
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            control_reg <= 32'h0000_0000;
            ready_reg   <= 32'h0000_0000;
            busy_reg    <= 1'b0;
            cnt_reg     <= 3'h0;
        end else if (ctlWr && !busy_reg) begin
            control_reg <= bus.wdata;
            ready_reg   <= 32'h0000_0000;                                   // [R15]
            busy_reg    <= 1'b1;
            cnt_reg     <= 3'h0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (done) begin
                busy_reg <= 1'b0;
                if (isStat)                       ready_reg <= RDY_STATS_RD; // [R5]
                else if (isMdio && isWr)          ready_reg <= RDY_MGMT_WR;
                else if (isMdio)                  ready_reg <= RDY_MGMT_RD;  // [R12]
                else if (mcRead)                  ready_reg <= RDY_AF_RD;    // [R8]
                else if (adr == ADR_MC_WORD0 || adr == ADR_MC_WORD1)
                                                  ready_reg <= RDY_AF_WR;    // [R9] [R10]
                else if (isWr)                    ready_reg <= RDY_CFG_WR;   // [R2]
                else                              ready_reg <= RDY_CFG_RD;   // [R1]
            end
        end
    end

    // data low word and local register space
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dataLow_reg <= 32'h0000_0000;
            flowCtl_reg <= '{default: 32'h0000_0000};
            mgmtCfg_reg <= '{default: 32'h0000_0000};
            mcWord0_reg <= '{default: 32'h0000_0000};
            mcTable_reg <= '{default: '{default: 48'h0000_0000_0000}};
        end else if (bus.req && bus.wr && bus.idx == IDX_DATA_LOW) begin
            dataLow_reg <= bus.wdata;
        end else if (done) begin
            if (isStat && !isWr)
                dataLow_reg <= statsValue[31:0];                             // [R5]
            else if (isMdio && !isWr)
                dataLow_reg <= phyReadValue;                                // [R12]
            else if (mcRead)
                dataLow_reg <= mcTable_reg[mac][mcIdx][31:0];               // [R7] [R8]
            else if (isWr && adr == ADR_MC_WORD0)
                mcWord0_reg[mac] <= dataLow_reg;                            // [R9]
            else if (isWr && adr == ADR_MC_WORD1 && dataLow_reg[MC_WR_BIT])
                mcTable_reg[mac][mcIdx] <= {dataLow_reg[15:0], mcWord0_reg[mac]}; // [R10]
            else if (isWr && adr == ADR_FLOWCTL)
                flowCtl_reg[mac] <= dataLow_reg;                            // [R2] [R4]
            else if (isWr && adr == ADR_MGMT_CFG)
                mgmtCfg_reg[mac] <= dataLow_reg;                            // [R11]
            else if (!isWr && isCfg && adr == ADR_FLOWCTL)
                dataLow_reg <= flowCtl_reg[mac];                            // [R1]
            else if (!isWr && isCfg && adr == ADR_MGMT_CFG)
                dataLow_reg <= mgmtCfg_reg[mac];                            // [R1]
        end
    end

    // outputs registered; transmit held until sync in pcs mode without autoneg
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flowTxEnable <= 2'b00;
            flowRxEnable <= 2'b00;
            mgmtEnable   <= 2'b00;
            tx_reg       <= 2'b00;
            statsAddr    <= 11'h000;
        end else begin
            flowTxEnable <= {flowCtl_reg[1][FC_TX_BIT], flowCtl_reg[0][FC_TX_BIT]}; // [R4]
            flowRxEnable <= {flowCtl_reg[1][FC_RX_BIT], flowCtl_reg[0][FC_RX_BIT]}; // [R4]
            mgmtEnable   <= {mgmtCfg_reg[1][MGMT_EN_BIT], mgmtCfg_reg[0][MGMT_EN_BIT]};
            tx_reg       <= (pcsMode && anOff) ? syncAcquiredStatus : 2'b11; // [R13]
            statsAddr    <= {mac, adr};
        end
    end
    assign txAllowed = tx_reg;
    assign bus.ack   = ack_reg;
    assign bus.rdata = rdata_reg;
endmodule : dhb_bridge

// >>> hdl/dhb_pkg.sv
// shared constants and types for the register-bus host access bridge
// What this block does
// [R1] config read: address, poll read-ready, read low
// [R2] config write: load low, address, poll write-ready
// [R3] control write-enable bit selects a write transaction
// [R4] flow control bits 29,30 enable both directions
// [R5] statistics read returns 64 bits high/low
// [R6] registers at word offsets 12,13,14,15
// [R7] multicast read: mask and index in low
// [R8] multicast read via word-1 address, filter ready
// [R9] multicast store: word 0 write, await ready
// [R10] multicast store: word 1 with mask, await ready
// [R11] management enable and divider before phy read
// [R12] phy read: address decode, management ready, low
// [R13] no transmit before sync acquired when autoneg off in pcs mode
// [R14] second mac select is address bit 10
// [R15] ready flags clear on start, set on completion
package dhb_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0]  IDX_DATA_HIGH  = 4'hC;
    localparam logic [3:0]  IDX_DATA_LOW   = 4'hD;
    localparam logic [3:0]  IDX_CONTROL    = 4'hE;
    localparam logic [3:0]  IDX_READY      = 4'hF;
    // control register fields
    localparam int          CTL_WREN_BIT   = 15;
    localparam int          CTL_SEL_BIT    = 10;
    localparam int          CTL_ADDR_W     = 10;
    // ready flag masks
    localparam logic [31:0] RDY_STATS_RD   = 32'h0000_0001;
    localparam logic [31:0] RDY_MGMT_RD    = 32'h0000_0002;
    localparam logic [31:0] RDY_CFG_RD     = 32'h0000_0020;
    localparam logic [31:0] RDY_AF_RD      = 32'h0000_0008;
    localparam logic [31:0] RDY_AF_WR      = 32'h0000_1000;
    localparam logic [31:0] RDY_CFG_WR     = 32'h0000_4000;
    localparam logic [31:0] RDY_MGMT_WR    = 32'h0000_0400;
    // local register space (10 bits, bit 9 selects config)
    localparam logic [9:0]  ADR_FLOWCTL    = 10'h2C0;
    localparam logic [9:0]  ADR_MGMT_CFG   = 10'h340;
    localparam logic [9:0]  ADR_MC_WORD0   = 10'h388;
    localparam logic [9:0]  ADR_MC_WORD1   = 10'h38C;
    localparam logic [9:0]  ADR_MDIO_DATA  = 10'h3B0;
    localparam logic [9:0]  ADR_MDIO_ADDR  = 10'h3B4;
    localparam int          FC_TX_BIT      = 30;
    localparam int          FC_RX_BIT      = 29;
    localparam int          MGMT_EN_BIT    = 6;
    localparam int          MC_RNW_BIT     = 23;
    localparam int          MC_WR_BIT      = 16;
    localparam int          MC_IDX_LSB     = 16;
    localparam int          CFG_AUTONEG    = 77;
    localparam int          CFG_VEC_W      = 80;
    // latency of one transaction, in clocks
    localparam int          XFER_CYCLES    = 4;
    // apb offsets of controller registers
    localparam logic [7:0]  APB_DATA_HIGH  = 8'h00;
    localparam logic [7:0]  APB_DATA_LOW   = 8'h04;
    localparam logic [7:0]  APB_COMMAND    = 8'h08;
    localparam logic [7:0]  APB_STATUS     = 8'h0C;
    localparam logic [7:0]  APB_RESULT_HI  = 8'h10;
    localparam logic [7:0]  APB_RESULT_LO  = 8'h14;
    typedef enum logic [1:0] {
        BUS_READ,
        BUS_WRITE
    } dhb_dir_t;
endpackage : dhb_pkg

// >>> hdl/dhb_if.sv
// register bus between the processor side and the bridge
`timescale 1ns/1ps
interface dhb_if;
    logic        req;     // one-cycle request strobe
    logic        wr;      // write when high
    logic [3:0]  idx;     // register index
    logic [31:0] wdata;   // write data
    logic        ack;     // one-cycle answer
    logic [31:0] rdata;   // read data, valid with ack
    modport bridge (input req, wr, idx, wdata, output ack, rdata);
    modport proc   (output req, wr, idx, wdata, input ack, rdata);
endinterface : dhb_if

// >>> hdl/dhb_proc.sv
// processor end: apb-driven sequencer that runs indirect transactions
`timescale 1ns/1ps
module dhb_proc
    import dhb_pkg::*;
(
    input  wire logic        clock,    // 20 MHz clock
    input  wire logic        rst_b,    // async reset, low
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb enable
    input  wire logic        pwrite,   // apb write
    input  wire logic [7:0]  paddr,    // apb byte address
    input  wire logic [31:0] pwdata,   // apb write data
    output logic             pready,   // apb ready
    output logic [31:0]      prdata,   // apb read data
    output logic             pslverr,  // apb error
    dhb_if.proc              bus       // register bus
);
    typedef enum logic [2:0] {S_IDLE, S_HIGH, S_LOW, S_CTL, S_POLL, S_RDH, S_RDL} dhb_st_t;
    dhb_st_t     st_reg;
    logic [31:0] dHi_reg, dLo_reg, cmd_reg, mask_reg, resHi_reg, resLo_reg;
    logic        busy_reg, wait_reg, req_reg, wr_reg;
    logic [3:0]  idx_reg;
    logic [31:0] wd_reg;

    wire apbAcc = psel && penable;
    wire apbWr  = apbAcc && pwrite;
    wire startCmd = apbWr && paddr == APB_COMMAND && !busy_reg;

    // apb slave: zero wait states, unmapped reads zero, error only for offsets past the map
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0; prdata <= 32'h0000_0000; pslverr <= 1'b0;
            dHi_reg <= 32'h0000_0000; dLo_reg <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > APB_RESULT_LO;
            unique case (paddr)
                APB_DATA_HIGH: prdata <= dHi_reg;
                APB_DATA_LOW:  prdata <= dLo_reg;
                APB_COMMAND:   prdata <= cmd_reg;
                APB_STATUS:    prdata <= {31'h0000_0000, busy_reg};
                APB_RESULT_HI: prdata <= resHi_reg;
                APB_RESULT_LO: prdata <= resLo_reg;
                default:       prdata <= 32'h0000_0000;
            endcase
            if (apbWr && paddr == APB_DATA_HIGH) dHi_reg <= pwdata;
            if (apbWr && paddr == APB_DATA_LOW)  dLo_reg <= pwdata;
        end
    end

    // sequencer: load data, write control, poll ready, read results
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= S_IDLE; busy_reg <= 1'b0; wait_reg <= 1'b0;
            req_reg <= 1'b0; wr_reg <= 1'b0; idx_reg <= 4'h0; wd_reg <= 32'h0000_0000;
            cmd_reg <= 32'h0000_0000; mask_reg <= 32'h0000_0000;
            resHi_reg <= 32'h0000_0000; resLo_reg <= 32'h0000_0000;
        end else begin
            req_reg <= 1'b0;
            if (req_reg) wait_reg <= 1'b1;
            unique case (st_reg)
                S_IDLE: if (startCmd) begin
                    cmd_reg <= pwdata; busy_reg <= 1'b1; st_reg <= S_HIGH;
                    mask_reg <= pwdata[31:16] == 16'h0000 ? 32'h0000_0000 : {16'h0000, pwdata[31:16]};
                end
                S_HIGH: if (!wait_reg && !req_reg) begin
                    req_reg <= 1'b1; wr_reg <= 1'b1; idx_reg <= IDX_DATA_HIGH; wd_reg <= dHi_reg;
                end else if (bus.ack) begin wait_reg <= 1'b0; st_reg <= S_LOW; end
                S_LOW: if (!wait_reg && !req_reg) begin                    // [R2] [R7] [R11]
                    req_reg <= 1'b1; wr_reg <= 1'b1; idx_reg <= IDX_DATA_LOW; wd_reg <= dLo_reg;
                end else if (bus.ack) begin wait_reg <= 1'b0; st_reg <= S_CTL; end
                S_CTL: if (!wait_reg && !req_reg) begin                    // [R3] [R14]
                    req_reg <= 1'b1; wr_reg <= 1'b1; idx_reg <= IDX_CONTROL;
                    wd_reg <= {16'h0000, cmd_reg[15:0]};
                end else if (bus.ack) begin wait_reg <= 1'b0; st_reg <= S_POLL; end
                S_POLL: if (!wait_reg && !req_reg) begin                   // [R1] [R9] [R10] [R12]
                    req_reg <= 1'b1; wr_reg <= 1'b0; idx_reg <= IDX_READY;
                end else if (bus.ack) begin
                    wait_reg <= 1'b0;
                    if ((bus.rdata & mask_reg) != 32'h0000_0000 || mask_reg == 32'h0000_0000)
                        st_reg <= S_RDH;
                end
                S_RDH: if (!wait_reg && !req_reg) begin                    // [R5] [R8]
                    req_reg <= 1'b1; wr_reg <= 1'b0; idx_reg <= IDX_DATA_HIGH;
                end else if (bus.ack) begin
                    wait_reg <= 1'b0; resHi_reg <= bus.rdata; st_reg <= S_RDL;
                end
                S_RDL: if (!wait_reg && !req_reg) begin
                    req_reg <= 1'b1; wr_reg <= 1'b0; idx_reg <= IDX_DATA_LOW;
                end else if (bus.ack) begin
                    wait_reg <= 1'b0; resLo_reg <= bus.rdata; busy_reg <= 1'b0; st_reg <= S_IDLE;
                end
            endcase
        end
    end
    assign bus.req   = req_reg;
    assign bus.wr    = wr_reg;
    assign bus.idx   = idx_reg;
    assign bus.wdata = wd_reg;
endmodule : dhb_proc

// >>> bench/dhb_checker.sv
// concurrent checks on the register bus between processor end and bridge
`timescale 1ns/1ps
module dhb_checker
    import dhb_pkg::*;
(
    input wire logic        clock,  // bus clock
    input wire logic        rst_b,  // async reset, low
    input wire logic        req,    // request strobe
    input wire logic        wr,     // write when high
    input wire logic [3:0]  idx,    // register index
    input wire logic [31:0] wdata,  // write data
    input wire logic        ack,    // answer strobe
    input wire logic [31:0] rdata   // read data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [31:0] ctlReg;
    logic [31:0] lowReg;
    // the flag that the last started transaction may raise
    function automatic logic [31:0] flagFor(input logic [31:0] c, input logic [31:0] lo);
        if (c[9:0] == ADR_MDIO_ADDR) return c[CTL_WREN_BIT] ? RDY_MGMT_WR : RDY_MGMT_RD;
        if (!c[9]) return RDY_STATS_RD;
        if (c[9:0] == ADR_MC_WORD1 && c[CTL_WREN_BIT] && lo[MC_RNW_BIT] && !lo[MC_WR_BIT]) return RDY_AF_RD;
        if (c[9:0] == ADR_MC_WORD0 || c[9:0] == ADR_MC_WORD1) return RDY_AF_WR;
        return c[CTL_WREN_BIT] ? RDY_CFG_WR : RDY_CFG_RD;
    endfunction : flagFor
    // shadow of what the processor wrote; results written back by the bridge are not tracked
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctlReg <= 32'h0000_0000;
            lowReg <= 32'h0000_0000;
        end else if (req && wr) begin
            if (idx == IDX_CONTROL) ctlReg <= wdata;
            if (idx == IDX_DATA_LOW) lowReg <= wdata;
        end
    end
    a_ack_after_req: assert property (req |=> ack)
        else $error("request not answered in the next cycle");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("answer without a request");
    a_req_single: assert property (req |=> !req)
        else $error("request held longer than one cycle");
    a_idx_in_map: assert property (req |-> idx >= IDX_DATA_HIGH)
        else $error("request outside the bridge registers");
    // the first poll reaches the bridge three cycles after the control write
    a_flags_clear_start: assert property (
        (req && wr && idx == IDX_CONTROL) ##3 (req && !wr && idx == IDX_READY) |=> rdata == 32'h0000_0000)
        else $error("ready flag not cleared by a new transaction");
    a_flags_onehot: assert property ((req && !wr && idx == IDX_READY) |=> $onehot0(rdata))
        else $error("more than one ready flag raised");
    a_flag_kind: assert property ((req && !wr && idx == IDX_READY)
        |=> (rdata == 32'h0000_0000 || rdata == flagFor(ctlReg, lowReg)))
        else $error("ready flag does not match the transaction kind");
    a_ctl_no_ack_gap: assert property ((req && wr && idx == IDX_CONTROL) |=> ack ##1 !ack)
        else $error("control write answer malformed");
endmodule : dhb_checker

// >>> bench/test_dcr_host_access_bridge.sv
// self-checking bench: apb-driven processor end facing the bridge
`timescale 1ns/1ps
module test_dcr_host_access_bridge
    import dhb_pkg::*;
;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, pcsMode;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, phyReadValue, q, d;
    logic [79:0] cfgVec;
    logic [63:0] statsValue;
    logic [1:0]  syncAcq, flowTx, flowRx, mgmtEn, txAllowed;
    logic [10:0] statsAddr;
    logic        e, m;
    logic [8:0]  a;
    int          err_total, checks;
    dhb_if dhbBus();
    dhb_bridge u_dhb_bridge(.clock(clock), .rst_b(rst_b), .bus(dhbBus), .bridgeSelectEnable(1'b1),
        .staticConfigVector(cfgVec), .pcsMode(pcsMode), .syncAcquiredStatus(syncAcq), .statsValue(statsValue),
        .phyReadValue(phyReadValue), .flowTxEnable(flowTx), .flowRxEnable(flowRx), .mgmtEnable(mgmtEn),
        .txAllowed(txAllowed), .statsAddr(statsAddr));
    dhb_proc u_dhb_proc(.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus(dhbBus));
    dhb_checker u_dhb_checker(.clock(clock), .rst_b(rst_b), .req(dhbBus.req), .wr(dhbBus.wr),
        .idx(dhbBus.idx), .wdata(dhbBus.wdata), .ack(dhbBus.ack), .rdata(dhbBus.rdata));
    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task final_report;
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] cmdWord(input logic [31:0] flag, input logic we, input logic s, input logic [9:0] ad);
        return {flag[15:0], we, 4'h0, s, ad};
    endfunction : cmdWord
    // load low word, start a command and wait until the sequencer is idle
    task run(input logic [31:0] low, input logic [31:0] cmd);
        int n;
        n = 0;
        apb(1'b1, APB_DATA_LOW, low, q, e);
        apb(1'b1, APB_COMMAND, cmd, q, e);
        do begin
            apb(1'b0, APB_STATUS, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        check({31'h0, q[0]}, 32'h0);
    endtask : run
    // the whole run is well under 2k cycles; this limit of 40k cycles is far beyond it
    initial begin
        #2_000_000;
        err_total++;
        final_report();
    end
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        pcsMode = 1'b1; syncAcq = 2'b00; statsValue = 64'h0; phyReadValue = 32'h0; cfgVec = 80'h0;
        err_total = 0; checks = 0;
        void'($urandom(6));
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, APB_STATUS, 32'h0, q, e);
        check(q, 32'h0);
        // flow control write and read back, both macs, both bits set first
        for (int i = 0; i < 8; i++) begin
            m = (i < 2) ? i[0] : 1'($urandom);
            d = (i < 2) ? 32'h6000_0000 : ($urandom & 32'h6000_0000);
            run(d, cmdWord(RDY_CFG_WR, 1'b1, m, ADR_FLOWCTL));
            check({30'h0, flowTx[m], flowRx[m]}, {30'h0, d[FC_TX_BIT], d[FC_RX_BIT]});
            run(32'h0, cmdWord(RDY_CFG_RD, 1'b0, m, ADR_FLOWCTL));
            apb(1'b0, APB_RESULT_LO, 32'h0, q, e);
            check(q, d);
        end
        // statistics reads, address space below bit 9
        for (int i = 0; i < 8; i++) begin
            statsValue <= {$urandom, $urandom};
            m = 1'($urandom);
            a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom);
            run(32'h0, cmdWord(RDY_STATS_RD, 1'b0, m, {1'b0, a}));
            apb(1'b0, APB_RESULT_HI, 32'h0, q, e);
            check(q, statsValue[63:32]);
            apb(1'b0, APB_RESULT_LO, 32'h0, q, e);
            check(q, statsValue[31:0]);
            check({21'h0, statsAddr}, {21'h0, m, 1'b0, a});
        end
        // management enable then phy read, then multicast store and read, each mac
        for (int i = 0; i < 2; i++) begin
            run(32'h0000_004A, cmdWord(RDY_CFG_WR, 1'b1, i[0], ADR_MGMT_CFG));
            check({31'h0, mgmtEn[i]}, 32'h1);
            phyReadValue <= $urandom;
            run(32'h0000_0020, cmdWord(RDY_MGMT_RD, 1'b0, i[0], ADR_MDIO_ADDR));
            apb(1'b0, APB_RESULT_LO, 32'h0, q, e);
            check(q, phyReadValue);
            run(32'hDEAF_CAFE, cmdWord(RDY_AF_WR, 1'b1, i[0], ADR_MC_WORD0));
            run(32'h0081_FACE, cmdWord(RDY_AF_WR, 1'b1, i[0], ADR_MC_WORD1));
            // stale high word must be replaced by the entry read back
            apb(1'b1, APB_DATA_HIGH, 32'hFFFF_FFFF, q, e);
            run(32'h0082_0000, cmdWord(RDY_AF_RD, 1'b1, i[0], ADR_MC_WORD1));
            apb(1'b0, APB_RESULT_HI, 32'h0, q, e);
            check(q, 32'h0);
            apb(1'b0, APB_RESULT_LO, 32'h0, q, e);
            check(q, 32'h0);
        end
        // transmit held back until sync is acquired, autoneg off
        for (int i = 0; i < 4; i++) begin
            cfgVec <= {16'h0, $urandom, $urandom};
            syncAcq <= i[1:0];
            repeat (4) @(posedge clock);
            check({30'h0, txAllowed}, {30'h0, i[1:0]});
        end
        // autoneg on, then no pcs layer: transmit never held
        syncAcq <= 2'b00;
        cfgVec <= 80'h2000_0000_0000_0000_0000;
        repeat (4) @(posedge clock);
        check({30'h0, txAllowed}, 32'h3);
        cfgVec <= 80'h0;
        pcsMode <= 1'b0;
        repeat (4) @(posedge clock);
        check({30'h0, txAllowed}, 32'h3);
        // offset past the map is refused
        apb(1'b0, 8'h18, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        final_report();
    end
endmodule : test_dcr_host_access_bridge
